// *** rtl/isr_pkg.sv ***
// shared constants and types for the two-wire register access slave and its master
package isr_pkg;
	localparam logic [2:0] ISR_ADDR_FIXED = 3'b010;
	// three-state address pin level codes
	localparam logic [1:0] ISR_PIN_LOW = 2'b00;
	localparam logic [1:0] ISR_PIN_FLOAT = 2'b01;
	localparam logic [1:0] ISR_PIN_HIGH = 2'b10;
	// address bit pairs contributed by one pin
	localparam logic [1:0] ISR_BITS_HIGH = 2'b00;
	localparam logic [1:0] ISR_BITS_FLOAT = 2'b10;
	localparam logic [1:0] ISR_BITS_LOW = 2'b11;
	localparam logic [7:0] ISR_PTR_RESET = 8'h00;
	localparam logic [3:0] ISR_BYTE_BITS = 4'h8;
	// write byte slots within one register write group
	localparam logic [1:0] ISR_SLOT_PTR = 2'h0;
	localparam logic [1:0] ISR_SLOT_MSB = 2'h1;
	localparam logic [1:0] ISR_SLOT_LSB = 2'h2;
	// master byte commands
	localparam logic [1:0] ISR_OP_START = 2'h0;
	localparam logic [1:0] ISR_OP_WRITE = 2'h1;
	localparam logic [1:0] ISR_OP_READ = 2'h2;
	localparam logic [1:0] ISR_OP_STOP = 2'h3;
	// serial clock quarter period, fast mode
	localparam int ISR_CLK_NS = 5;
	localparam int ISR_QUARTER_NS = 625;
	localparam int ISR_QUARTER_CYC = (ISR_QUARTER_NS + ISR_CLK_NS - 1) / ISR_CLK_NS;
	typedef enum logic [2:0] {
		D_IDLE, D_ADDR, D_ADDR_ACK, D_WR, D_WR_ACK, D_TX, D_RX_ACK
	} isr_dev_state_t;
	typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} isr_mst_state_t;
endpackage

// *** rtl/isr_if.sv ***
// two-wire bus between the register access slave and its master
`timescale 1ns/100ps
`default_nettype none
interface isr_if;
	logic m_scl_o;
	logic m_scl_oe_n;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;
	logic scl;
	logic sda;
	// open-drain wired-and with pull-ups
	assign scl = m_scl_oe_n | m_scl_o;
	assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
	modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input sda);
	modport device (output d_sda_o, d_sda_oe_n, input scl, sda);
endinterface
`default_nettype wire

// *** rtl/isr_master.sv ***
// byte-level two-wire bus master end
`timescale 1ns/100ps
`default_nettype none
module isr_master import isr_pkg::*; #(
	parameter int unsigned QUARTER_CYC = ISR_QUARTER_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	isr_if.master bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_nack,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_ack
);
	if (QUARTER_CYC < 2 || QUARTER_CYC > 65535) begin : g_bad_quarter
		$error("QUARTER_CYC out of range");
	end

	typedef struct packed {
		isr_mst_state_t st;
		logic [1:0] ph;
		logic [15:0] cnt;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic [7:0] rx;
		logic rd;
		logic nack;
		logic ack_seen;
		logic scl_rel;
		logic sda_rel;
		logic [1:0] sda_s;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic rsp_ack;
	} isr_mst_t;

	localparam isr_mst_t MST_RST = '{st: M_IDLE, scl_rel: 1'b1, sda_rel: 1'b1,
		sda_s: 2'b11, default: '0};

	isr_mst_t q;
	isr_mst_t next_q;
	logic tick;

	assign tick = (q.st != M_IDLE) && (q.cnt == 16'(QUARTER_CYC - 1));
	assign cmd_ready = (q.st == M_IDLE);

	always_comb begin
		next_q = q;
		next_q.rsp_valid = 1'b0;
		next_q.sda_s = {q.sda_s[0], bus.sda};
		next_q.cnt = (q.st == M_IDLE || tick) ? 16'h0000 : q.cnt + 16'h0001;
		if (tick) begin
			next_q.ph = q.ph + 2'h1;
		end
		unique case (q.st)
			M_IDLE: begin
				next_q.ph = 2'h0;
				next_q.bitn = 4'h0;
				if (cmd_valid) begin
					next_q.sh = cmd_data;
					next_q.rd = (cmd_op == ISR_OP_READ);
					next_q.nack = cmd_nack;
					unique case (cmd_op)
						ISR_OP_START: next_q.st = M_START; // see [R1] see [R12]
						ISR_OP_WRITE: next_q.st = M_BIT;
						ISR_OP_READ: next_q.st = M_BIT;
						ISR_OP_STOP: next_q.st = M_STOP; // see [R6]
					endcase
				end
			end
			M_START: if (tick) begin
				// works from idle and as a repeated start after an ack bit
				unique case (q.ph)
					2'h0: next_q.sda_rel = 1'b1;
					2'h1: next_q.scl_rel = 1'b1;
					2'h2: next_q.sda_rel = 1'b0;
					2'h3: begin
						next_q.scl_rel = 1'b0;
						next_q.st = M_BIT;
					end
				endcase
			end
			M_BIT: if (tick) begin
				unique case (q.ph)
					2'h0: begin
						if (q.bitn < ISR_BYTE_BITS) begin
							next_q.sda_rel = q.rd | q.sh[7];
						end else begin
							next_q.sda_rel = q.rd ? q.nack : 1'b1; // see [R13] see [R14]
						end
					end
					2'h1: next_q.scl_rel = 1'b1;
					2'h2: begin
						if (q.bitn < ISR_BYTE_BITS) begin
							next_q.rx = {q.rx[6:0], q.sda_s[1]};
						end else begin
							next_q.ack_seen = ~q.sda_s[1];
						end
					end
					2'h3: begin
						next_q.scl_rel = 1'b0;
						next_q.sh = {q.sh[6:0], 1'b0};
						next_q.bitn = q.bitn + 4'h1;
						if (q.bitn == ISR_BYTE_BITS) begin
							next_q.st = M_IDLE;
							next_q.rsp_valid = 1'b1;
							next_q.rsp_data = q.rx;
							next_q.rsp_ack = q.rd ? ~q.nack : q.ack_seen;
						end
					end
				endcase
			end
			M_STOP: if (tick) begin
				unique case (q.ph)
					2'h0: next_q.sda_rel = 1'b0;
					2'h1: next_q.scl_rel = 1'b1;
					2'h2: next_q.sda_rel = 1'b1;
					2'h3: begin
						next_q.st = M_IDLE;
						next_q.rsp_valid = 1'b1;
						next_q.rsp_ack = 1'b1;
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= MST_RST;
		end else begin
			q <= next_q;
		end
	end

	assign bus.m_scl_o = 1'b0;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_scl_oe_n = q.scl_rel;
	assign bus.m_sda_oe_n = q.sda_rel;
	assign rsp_valid = q.rsp_valid;
	assign rsp_data = q.rsp_data;
	assign rsp_ack = q.rsp_ack;
endmodule
`default_nettype wire

// *** rtl/isr_device.sv ***
// two-wire slave end: register pointer, register writes and two-byte reads
`timescale 1ns/100ps
`default_nettype none
// Function
// [R1] master opens with start, address, direction
// [R2] slave acks address, pointer and data bytes
// [R3] register data: high byte, then low byte
// [R4] after two data bytes, next is pointer
// [R5] several registers per write transaction
// [R6] master ends write with stop
// [R7] every read returns both register bytes
// [R8] pointer loaded by separate one-byte write
// [R9] repeated reads from same pointed register
// [R10] pointer survives stop
// [R11] new register needs new pointer write
// [R12] read opens with address, direction high
// [R13] master acks all but final byte
// [R14] final nack releases data line
// [R15] start and rest in partial power-down; a stop leaves it powered up while autocycle_en is high
// [R16] addressing leaves partial power-down
// [R17] command and autocycle conversion modes
// [R18] address 010 plus two three-state pins
// [R19] no read and write in one transaction
// [R20] stop mid-write leaves register unchanged
// [R21] any start restarts address reception
module isr_device import isr_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	isr_if.device bus,
	input wire logic [1:0] address_select_low_pin,
	input wire logic [1:0] address_select_high_pin,
	input wire logic autocycle_en,
	input wire logic [15:0] reg_rd_data,
	output logic [7:0] reg_ptr,
	output logic reg_wr_en,
	output logic [7:0] reg_wr_addr,
	output logic [15:0] reg_wr_data,
	output logic conv_start,
	output logic partial_power_down
);
	typedef struct packed {
		isr_dev_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rd;
		logic [1:0] slot;
		logic [7:0] ptr;
		logic [7:0] msb;
		logic [7:0] lo;
		logic half;
		logic acked;
		logic drive_low;
		logic pd;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [15:0] wr_data;
		logic conv_req;
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
	} isr_dev_t;

	localparam isr_dev_t DEV_RST = '{st: D_IDLE, pd: 1'b1, ptr: ISR_PTR_RESET,
		scl_sync: 3'b111, sda_sync: 3'b111, default: '0};

	function automatic logic [1:0] pin_bits(input logic [1:0] level);
		unique case (level)
			ISR_PIN_HIGH: pin_bits = ISR_BITS_HIGH;
			ISR_PIN_FLOAT: pin_bits = ISR_BITS_FLOAT;
			default: pin_bits = ISR_BITS_LOW;
		endcase
	endfunction

	isr_dev_t q;
	isr_dev_t next_q;
	logic scl_rise;
	logic scl_fall;
	logic sda_in;
	logic start_seen;
	logic stop_seen;
	logic [6:0] my_addr;
	logic tx_go;
	logic [7:0] tx_byte;

	// bits [1] and [2] of each sync chain are the stable and previous samples
	assign sda_in = q.sda_sync[1];
	assign scl_rise = q.scl_sync[1] & ~q.scl_sync[2];
	assign scl_fall = ~q.scl_sync[1] & q.scl_sync[2];
	assign start_seen = q.scl_sync[1] & q.scl_sync[2] & ~q.sda_sync[1] & q.sda_sync[2];
	assign stop_seen = q.scl_sync[1] & q.scl_sync[2] & q.sda_sync[1] & ~q.sda_sync[2];
	assign my_addr = {ISR_ADDR_FIXED, pin_bits(q.pin_s2[3:2]), pin_bits(q.pin_s2[1:0])}; // see [R18]

	always_comb begin
		next_q = q;
		tx_go = 1'b0;
		tx_byte = 8'h00;
		next_q.wr_en = 1'b0;
		next_q.conv_req = 1'b0;
		next_q.scl_sync = {q.scl_sync[1:0], bus.scl};
		next_q.sda_sync = {q.sda_sync[1:0], bus.sda};
		next_q.pin_s1 = {address_select_high_pin, address_select_low_pin};
		next_q.pin_s2 = q.pin_s1;
		if (start_seen) begin
			next_q.st = D_ADDR; // see [R21]
			next_q.cnt = 4'h0;
			next_q.drive_low = 1'b0;
		end else if (stop_seen) begin
			// a half-written register never reaches reg_wr_en; pointer is kept
			next_q.st = D_IDLE; // see [R20] see [R10]
			next_q.drive_low = 1'b0;
			if (!autocycle_en) begin
				next_q.pd = 1'b1; // see [R15]
			end
		end else begin
			unique case (q.st)
				D_IDLE: ;
				D_ADDR, D_WR: begin
					if (scl_rise) begin
						next_q.sh = {q.sh[6:0], sda_in};
						next_q.cnt = q.cnt + 4'h1;
					end
					if (scl_fall && q.cnt == ISR_BYTE_BITS) begin
						next_q.cnt = 4'h0;
						if (q.st == D_ADDR) begin
							if (q.sh[7:1] == my_addr) begin
								next_q.drive_low = 1'b1; // see [R2]
								next_q.rd = q.sh[0]; // see [R19]
								next_q.pd = 1'b0; // see [R16]
								next_q.slot = ISR_SLOT_PTR;
								next_q.st = D_ADDR_ACK;
							end else begin
								next_q.st = D_IDLE;
							end
						end else begin
							next_q.drive_low = 1'b1; // see [R2]
							next_q.st = D_WR_ACK;
							unique case (q.slot)
								ISR_SLOT_PTR: begin
									next_q.ptr = q.sh; // see [R8] see [R11]
									next_q.slot = ISR_SLOT_MSB;
								end
								ISR_SLOT_MSB: begin
									next_q.msb = q.sh; // see [R3]
									next_q.slot = ISR_SLOT_LSB;
								end
								default: begin
									next_q.wr_en = 1'b1;
									next_q.wr_addr = q.ptr;
									next_q.wr_data = {q.msb, q.sh}; // see [R3]
									next_q.slot = ISR_SLOT_PTR; // see [R4] see [R5]
								end
							endcase
						end
					end
				end
				D_ADDR_ACK: if (scl_fall) begin
					if (q.rd) begin
						tx_go = 1'b1;
						tx_byte = reg_rd_data[15:8]; // see [R7] see [R9]
						next_q.lo = reg_rd_data[7:0];
						next_q.half = 1'b0;
						next_q.conv_req = ~autocycle_en; // see [R17]
					end else begin
						next_q.drive_low = 1'b0;
						next_q.st = D_WR;
					end
				end
				D_WR_ACK: if (scl_fall) begin
					next_q.drive_low = 1'b0;
					next_q.st = D_WR;
				end
				D_TX: if (scl_fall) begin
					if (q.cnt == ISR_BYTE_BITS) begin
						next_q.drive_low = 1'b0;
						next_q.st = D_RX_ACK;
					end else begin
						next_q.drive_low = ~q.sh[7];
						next_q.sh = {q.sh[6:0], 1'b0};
						next_q.cnt = q.cnt + 4'h1;
					end
				end
				D_RX_ACK: begin
					if (scl_rise) begin
						next_q.acked = ~sda_in;
					end
					if (scl_fall) begin
						if (!q.acked) begin
							next_q.st = D_IDLE; // see [R14]
						end else if (!q.half) begin
							tx_go = 1'b1;
							tx_byte = q.lo; // see [R7]
							next_q.half = 1'b1;
						end else begin
							// each new pair re-reads the pointed register
							tx_go = 1'b1;
							tx_byte = reg_rd_data[15:8]; // see [R9] see [R13]
							next_q.lo = reg_rd_data[7:0];
							next_q.half = 1'b0;
							next_q.conv_req = ~autocycle_en; // see [R17]
						end
					end
				end
			endcase
			if (tx_go) begin
				next_q.drive_low = ~tx_byte[7];
				next_q.sh = {tx_byte[6:0], 1'b0};
				next_q.cnt = 4'h1;
				next_q.st = D_TX;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= DEV_RST;
		end else begin
			q <= next_q;
		end
	end

	assign bus.d_sda_o = 1'b0;
	assign bus.d_sda_oe_n = ~q.drive_low;
	assign reg_ptr = q.ptr;
	assign reg_wr_en = q.wr_en;
	assign reg_wr_addr = q.wr_addr;
	assign reg_wr_data = q.wr_data;
	assign conv_start = q.conv_req;
	assign partial_power_down = q.pd;
endmodule
`default_nettype wire

// *** verification/isr_bus_asserts.sv ***
// wire-level checks on the two-wire bus between the master and slave ends
`timescale 1ns/100ps
`default_nettype none
module isr_bus_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic m_scl_o,
	input wire logic m_scl_oe_n,
	input wire logic m_sda_o,
	input wire logic m_sda_oe_n,
	input wire logic d_sda_o,
	input wire logic d_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// a driven high would fight the pull-ups
	AST_OPEN_DRAIN: assert property (!m_scl_o && !m_sda_o && !d_sda_o)
		else $error("a bus end drives a line high");
	AST_SCL_HIGH_TIME: assert property ($rose(scl) |-> scl[*8])
		else $error("serial clock high phase too short");
	AST_DEV_TAKE_LOW: assert property ($fell(d_sda_oe_n) |-> !scl)
		else $error("slave took data line while clock high");
	AST_DEV_RELEASE_LOW: assert property ($rose(d_sda_oe_n) |-> !scl)
		else $error("slave released data line while clock high");
	AST_DEV_HOLD_HIGH: assert property ($rose(scl) && !d_sda_oe_n |-> (!d_sda_oe_n)[*8])
		else $error("slave data bit not held over clock high");
	AST_START_BY_MASTER: assert property ($fell(sda) && scl |-> !m_sda_oe_n && d_sda_oe_n)
		else $error("start condition not made by master");
	AST_STOP_RELEASED: assert property ($rose(sda) && scl |-> d_sda_oe_n)
		else $error("slave still drives at stop");
	AST_DEV_DRIVE_BOUND: assert property ($fell(d_sda_oe_n) |-> ##[1:320] d_sda_oe_n)
		else $error("slave held data line too long");
	COV_ACK: cover property ($fell(d_sda_oe_n));
	COV_START: cover property ($fell(sda) && scl);
	COV_STOP: cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

// *** verification/i2c_slave_register_access_test.sv ***
// self-checking bench: master and slave ends joined over the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_register_access_test import isr_pkg::*;;
	logic clk, resetn, cmd_valid, cmd_ready, cmd_nack, rsp_valid, rsp_ack, autocycle_en;
	logic reg_wr_en, conv_start, partial_power_down;
	logic [1:0] cmd_op, pin_lo, pin_hi;
	logic [7:0] cmd_data, rsp_data, reg_ptr, reg_wr_addr, p1, p2;
	logic [15:0] reg_rd_data, reg_wr_data, d1, d2;
	logic [15:0] mem [256];
	logic [6:0] adr;
	logic [9:0] e;
	logic [9:0] rq [$];
	logic [23:0] wq [$];
	int err_total, checks, convs;
	isr_if bus ();
	// short quarter period keeps the run brief
	isr_master #(.QUARTER_CYC(8)) i_isr_master (.clk(clk), .resetn(resetn), .bus(bus),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
	isr_device i_isr_device (.clk(clk), .resetn(resetn), .bus(bus),
		.address_select_low_pin(pin_lo), .address_select_high_pin(pin_hi),
		.autocycle_en(autocycle_en), .reg_rd_data(reg_rd_data), .reg_ptr(reg_ptr),
		.reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
		.conv_start(conv_start), .partial_power_down(partial_power_down));
	isr_bus_asserts i_isr_bus_asserts (.clk(clk), .resetn(resetn), .m_scl_o(bus.m_scl_o),
		.m_scl_oe_n(bus.m_scl_oe_n), .m_sda_o(bus.m_sda_o), .m_sda_oe_n(bus.m_sda_oe_n),
		.d_sda_o(bus.d_sda_o), .d_sda_oe_n(bus.d_sda_oe_n), .scl(bus.scl), .sda(bus.sda));
	// register file behind the slave
	assign reg_rd_data = mem[reg_ptr];
	task automatic wrap_up();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
		checks++;
		if (g !== x) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic nk);
		int i;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		cmd_nack <= nk;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (cmd_ready !== 1'b1 && i < 9);
		if (cmd_ready !== 1'b1) begin
			err_total++;
			wrap_up();
		end
		@(posedge clk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge clk);
			i++;
		end while (rsp_valid !== 1'b1 && i < 400);
		if (rsp_valid !== 1'b1) begin
			err_total++;
			wrap_up();
		end
	endtask
	task automatic st(input logic [7:0] a, input logic ak);
		rq.push_back({1'b1, a, ak});
		cmd(ISR_OP_START, a, 1'b0);
	endtask
	task automatic wb(input logic [7:0] b);
		rq.push_back({1'b1, b, 1'b1});
		cmd(ISR_OP_WRITE, b, 1'b0);
	endtask
	task automatic rb(input logic [7:0] b, input logic nk);
		rq.push_back({1'b1, b, !nk});
		cmd(ISR_OP_READ, 8'h00, nk);
	endtask
	task automatic sp();
		rq.push_back(10'h001);
		cmd(ISR_OP_STOP, 8'h00, 1'b0);
		repeat (2) @(negedge clk);
		chk("idle lines", 24'h000003, 24'({bus.scl, bus.sda}));
	endtask
	task automatic wreg(input logic [7:0] p, input logic [15:0] d);
		wb(p);
		wb(d[15:8]);
		wq.push_back({p, d});
		wb(d[7:0]);
	endtask
	function automatic logic [1:0] pbits(input logic [1:0] c);
		if (c == ISR_PIN_HIGH)
			return ISR_BITS_HIGH;
		return (c == ISR_PIN_FLOAT) ? ISR_BITS_FLOAT : ISR_BITS_LOW;
	endfunction
	// the register file changes on the rising edge, like every other slave input
	always @(posedge clk) begin
		if (reg_wr_en === 1'b1)
			mem[reg_wr_addr] <= reg_wr_data;
	end
	// outputs are looked at mid-cycle, after the edge's updates landed
	always @(negedge clk) begin
		if (reg_wr_en === 1'b1) begin
			if (wq.size() == 0)
				chk("stray write", 24'h000001, 24'h000000);
			else
				chk("register write", wq.pop_front(), {reg_wr_addr, reg_wr_data});
		end
		if (rsp_valid === 1'b1) begin
			if (rq.size() == 0) begin
				chk("stray response", 24'h000001, 24'h000000);
			end else begin
				e = rq.pop_front();
				chk("response", 24'(e[8:0]),
					24'({e[9] ? rsp_data : e[8:1], rsp_ack}));
			end
		end
		if (conv_start === 1'b1)
			convs++;
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		void'($urandom(32'h1be3));
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_data = 8'h00;
		cmd_nack = 1'b0;
		autocycle_en = 1'b0;
		pin_lo = 2'($urandom % 3);
		pin_hi = 2'($urandom % 3);
		err_total = 0;
		checks = 0;
		convs = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(negedge clk);
		adr = {ISR_ADDR_FIXED, pbits(pin_hi), pbits(pin_lo)};
		p1 = 8'($urandom);
		p2 = p1 + 8'h01;
		d1 = 16'($urandom);
		d2 = 16'($urandom);
		chk("power down", 24'h000001, 24'(partial_power_down));
		chk("pointer", 24'(ISR_PTR_RESET), 24'(reg_ptr));
		st({adr ^ 7'h01, 1'b0}, 1'b0);
		sp();
		chk("power down", 24'h000001, 24'(partial_power_down));
		st({adr, 1'b0}, 1'b1);
		chk("power down", 24'h000000, 24'(partial_power_down));
		wreg(p1, d1);
		wreg(p2, d2);
		sp();
		chk("power down", 24'h000001, 24'(partial_power_down));
		chk("pointer", 24'(p2), 24'(reg_ptr));
		// a restart and a stop both cut a half-written register
		st({adr, 1'b0}, 1'b1);
		wb(p1);
		wb(8'h5a);
		st({adr, 1'b0}, 1'b1);
		wb(p1);
		wb(8'ha5);
		sp();
		chk("pointer", 24'(p1), 24'(reg_ptr));
		st({adr, 1'b1}, 1'b1);
		rb(d1[15:8], 1'b0);
		rb(d1[7:0], 1'b0);
		rb(d1[15:8], 1'b0);
		rb(d1[7:0], 1'b1);
		sp();
		st({adr, 1'b0}, 1'b1);
		wb(p2);
		sp();
		@(posedge clk);
		autocycle_en <= 1'b1;
		st({adr, 1'b1}, 1'b1);
		rb(d2[15:8], 1'b0);
		rb(d2[7:0], 1'b1);
		sp();
		chk("power down", 24'h000000, 24'(partial_power_down));
		repeat (4) @(negedge clk);
		chk("pending", 24'h000000, 24'(rq.size() + wq.size()));
		chk("conversions", 24'h000002, 24'(convs));
		wrap_up();
	end
endmodule
`default_nettype wire
